// ---- shared/tem_pkg.sv ----
package tem_pkg;

    // register offsets
    localparam logic [15:0] REG_PEAK_TRACKING_ERROR    = 16'h111e;
    localparam logic [15:0] REG_TRACKING_ERROR_LIMIT   = 16'h121c;
    localparam logic [15:0] REG_POSITION_DEVIATION_NOW = 16'h1e24;

    // limit range and reset value, user units (10000 per revolution)
    localparam logic [31:0] LIMIT_RESET = 32'h0000_2710;
    localparam logic [31:0] LIMIT_MIN   = 32'h0000_0001;
    localparam logic [31:0] LIMIT_MAX   = 32'h001e_8480;
    localparam logic [31:0] PEAK_RESET  = 32'h0000_0000;
    localparam logic [31:0] USR_PER_REV = 32'h0000_2710;
    localparam logic [31:0] SEC_PER_MIN = 32'h0000_003c;

    // evaluation tick
    localparam int TICK_TIME_NS  = 1000000;
    localparam int CLK_PERIOD_NS = 5;
    localparam int TICK_CYCLES   = TICK_TIME_NS / CLK_PERIOD_NS;

    localparam logic [3:0] ERR_CLASS_RESET = 4'h1;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [15:0] addr;
        logic [31:0] wdata;
    } tem_req_t;

    typedef struct packed {
        logic        valid;
        logic        err;
        logic [31:0] rdata;
    } tem_rsp_t;

    typedef struct packed {
        logic [31:0] setpoint;
        logic [31:0] actual;
        logic [31:0] speed_offset;
    } tem_pos_t;

    typedef struct packed {
        logic       active;
        logic [3:0] err_class;
    } tem_fault_t;

endpackage

// ---- hdl/tem_regfile.sv ----
`timescale 1ns/1ps
module tem_regfile
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // write side
    input  wire logic        limit_we,
    input  wire logic [31:0] limit_wdata,
    input  wire logic        peak_clear,
    input  wire logic        peak_upd,
    input  wire logic [31:0] peak_val,
    // stored values
    output logic      [31:0] limit_q,
    output logic      [31:0] peak_q
);

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            limit_q <= tem_pkg::LIMIT_RESET;
        else if (limit_we)
        begin
            // out of range values are clamped into the legal span
            if (limit_wdata < tem_pkg::LIMIT_MIN)
                limit_q <= tem_pkg::LIMIT_MIN;
            else if (limit_wdata > tem_pkg::LIMIT_MAX)
                limit_q <= tem_pkg::LIMIT_MAX;
            else
                limit_q <= limit_wdata;
        end
    end

    // a peak update in the clear cycle wins so no event is lost
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            peak_q <= tem_pkg::PEAK_RESET;
        else if (peak_upd)
            peak_q <= peak_val;
        else if (peak_clear)
            peak_q <= tem_pkg::PEAK_RESET;
    end

endmodule

// ---- hdl/tem_monitor.sv ----
`timescale 1ns/1ps
module tem_monitor
#(
    // tick period in cycles; a bench may shorten it to keep runs short
    parameter int TICK_CYCLES = tem_pkg::TICK_CYCLES
)
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              nrst,
    // position inputs, same clock domain, scaled in user units
    input  wire tem_pkg::tem_pos_t pos,
    // fault configuration and acknowledge
    input  wire logic [3:0]        err_class_cfg,
    input  wire logic              fault_ack,
    // parameter access
    input  wire tem_pkg::tem_req_t req,
    output tem_pkg::tem_rsp_t      rsp,
    // fault, motion stop and evaluation tick
    output tem_pkg::tem_fault_t    fault,
    output logic                   stop_motion,
    output logic                   tick
);

    typedef enum logic [1:0] {TEM_IDLE, TEM_EVAL, TEM_FAULT} tem_state_t;

    function automatic logic [31:0] tem_abs(input logic [31:0] v);
        tem_abs = v[31] ? 32'(-v) : v;
    endfunction

    localparam logic [17:0] TICK_LAST = 18'(TICK_CYCLES - 1);

    tem_state_t  state_q;
    logic [17:0] tick_cnt_q;
    logic [31:0] dev_q;
    logic [31:0] track_q;
    logic [31:0] limit_q;
    logic [31:0] peak_q;
    logic [3:0]  class_q;
    logic        tick_hit;
    logic [31:0] raw_dev;
    logic [31:0] track_err;
    logic [31:0] track_mag;
    logic        wr_limit;
    logic        wr_peak;
    logic        peak_upd;
    logic        addr_ok;

    assign tick_hit  = (tick_cnt_q == TICK_LAST);
    // wraps modulo 2^32, matching the signed register range
    assign raw_dev   = pos.setpoint - pos.actual;
    assign track_err = raw_dev - pos.speed_offset;
    assign track_mag = tem_abs(track_err);

    assign wr_limit = req.valid && req.write && (req.addr == tem_pkg::REG_TRACKING_ERROR_LIMIT);
    assign wr_peak  = req.valid && req.write && (req.addr == tem_pkg::REG_PEAK_TRACKING_ERROR);
    assign peak_upd = (state_q == TEM_EVAL) && (tem_abs(track_q) > peak_q);

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            tick_cnt_q <= '0;
        else if (tick_hit)
            tick_cnt_q <= '0;
        else
            tick_cnt_q <= tick_cnt_q + 18'h00001;
    end

    assign tick = tick_hit;

    // sample both values at the tick so the evaluation uses one snapshot
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            dev_q   <= '0;
            track_q <= '0;
        end
        else if (tick_hit)
        begin
            dev_q   <= raw_dev;
            track_q <= track_err;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_q <= TEM_IDLE;
            class_q <= tem_pkg::ERR_CLASS_RESET;
        end
        else
        begin
            case (state_q)
                TEM_IDLE:
                begin
                    if (tick_hit)
                        state_q <= TEM_EVAL;
                end
                TEM_EVAL:
                begin
                    if (tem_abs(track_q) > limit_q)
                    begin
                        state_q <= TEM_FAULT;
                        class_q <= err_class_cfg;
                    end
                    else
                        state_q <= TEM_IDLE;
                end
                TEM_FAULT:
                begin
                    // fault holds until acknowledged; re-trips on next tick if still over
                    if (fault_ack)
                        state_q <= TEM_IDLE;
                end
                default:
                    state_q <= TEM_IDLE;
            endcase
        end
    end

    assign stop_motion  = (state_q == TEM_FAULT);
    // one driver for the whole struct
    assign fault = '{active: (state_q == TEM_FAULT), err_class: class_q};

    tem_regfile u_regfile
    (
        .clk         (clk),
        .nrst        (nrst),
        .limit_we    (wr_limit),
        .limit_wdata (req.wdata),
        .peak_clear  (wr_peak),
        .peak_upd    (peak_upd),
        .peak_val    (tem_abs(track_q)),
        .limit_q     (limit_q),
        .peak_q      (peak_q)
    );

    always_comb
    begin
        addr_ok = (req.addr == tem_pkg::REG_PEAK_TRACKING_ERROR)
               || (req.addr == tem_pkg::REG_TRACKING_ERROR_LIMIT)
               || (req.addr == tem_pkg::REG_POSITION_DEVIATION_NOW);
    end

    // one cycle response; writes to the read-only deviation flag an error
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rsp.valid <= 1'b0;
            rsp.err   <= 1'b0;
            rsp.rdata <= '0;
        end
        else
        begin
            rsp.valid <= req.valid;
            rsp.err   <= req.valid && (!addr_ok || (req.write
                         && req.addr == tem_pkg::REG_POSITION_DEVIATION_NOW));
            rsp.rdata <= '0;
            if (req.valid && !req.write)
            begin
                case (req.addr)
                    tem_pkg::REG_PEAK_TRACKING_ERROR:    rsp.rdata <= peak_q;
                    tem_pkg::REG_TRACKING_ERROR_LIMIT:   rsp.rdata <= limit_q;
                    tem_pkg::REG_POSITION_DEVIATION_NOW: rsp.rdata <= dev_q;
                    default:                             rsp.rdata <= '0;
                endcase
            end
        end
    end

endmodule

// ---- bench/tem_pos_src.sv ----
`timescale 1ns/1ps
module tem_pos_src
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // commanded setpoint, following error and feedforward part
    input  wire logic [31:0] sp,
    input  wire logic [31:0] fe,
    input  wire logic [31:0] ff,
    // to the monitor
    output tem_pkg::tem_pos_t pos
);
    // encoder lags the setpoint by fe, all in user units
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            pos <= '0;
        else
            pos <= '{sp, sp - fe, ff};
    end
endmodule

// ---- bench/tem_monitor_asserts.sv ----
`timescale 1ns/1ps
module tem_monitor_chk
(
    // clock and reset
    input wire logic                clk,
    input wire logic                nrst,
    // watched ports
    input wire tem_pkg::tem_req_t   req,
    input wire tem_pkg::tem_rsp_t   rsp,
    input wire tem_pkg::tem_fault_t fault,
    input wire logic                stop_motion,
    input wire logic                tick,
    input wire logic                fault_ack
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    a_rsp_one_later: assert property (req.valid |=> rsp.valid)
        else $error("response missing");
    a_rsp_no_extra: assert property (rsp.valid |-> $past(req.valid))
        else $error("response without request");
    a_dev_write_err: assert property (
        req.valid && req.write && req.addr == 16'h1e24 |=> rsp.err)
        else $error("deviation write accepted");
    a_limit_in_range: assert property (req.valid && !req.write && req.addr == 16'h121c
        |=> rsp.rdata inside {[32'h1:32'h1e8480]})
        else $error("limit out of range");
    a_write_rdata_zero: assert property (req.valid && req.write |=> rsp.rdata == 32'h0)
        else $error("write returned data");
    a_stop_is_fault: assert property (stop_motion == fault.active)
        else $error("stop differs from fault");
    a_trip_after_tick: assert property ($rose(fault.active) |-> $past(tick, 2))
        else $error("fault off tick");
    a_tick_spacing: assert property (tick |=> !tick [*8])
        else $error("tick too soon");
    a_ack_clears: assert property (fault.active && fault_ack |-> ##[1:2] !fault.active)
        else $error("fault not left");
    cover property ($rose(fault.active));
    cover property (rsp.valid && rsp.err);
    cover property (fault.active && fault_ack);
endmodule
bind tem_monitor tem_monitor_chk chk_u (.clk(clk), .nrst(nrst), .req(req), .rsp(rsp),
    .fault(fault), .stop_motion(stop_motion), .tick(tick), .fault_ack(fault_ack));

// ---- bench/tb.sv ----
`timescale 1ns/1ps
module tb;
    logic                clk = 1'b0;
    logic                nrst = 1'b0;
    logic                fault_ack = 1'b0;
    logic [3:0]          cls = 4'h0;
    logic [31:0]         sp = 32'h0, fe = 32'h0, ff = 32'h0, rd;
    logic                er, stop_motion, tick;
    tem_pkg::tem_req_t   req = '0;
    tem_pkg::tem_rsp_t   rsp;
    tem_pkg::tem_pos_t   pos;
    tem_pkg::tem_fault_t fault;
    int                  miscompares = 0, total_checks = 0;
    // shortened tick so the whole run stays small
    localparam int       TICK_N = 1000;
    always #2.5 clk = ~clk;
    tem_pos_src src_u (.clk(clk), .nrst(nrst), .sp(sp), .fe(fe), .ff(ff), .pos(pos));
    tem_monitor #(.TICK_CYCLES(TICK_N)) dut_u (.clk(clk), .nrst(nrst), .pos(pos),
        .err_class_cfg(cls), .fault_ack(fault_ack), .req(req), .rsp(rsp), .fault(fault),
        .stop_motion(stop_motion), .tick(tick));
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        total_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // answer stands one cycle, so it is taken at the next falling edge
    task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d);
        @(negedge clk) req = '{1'b1, w, a, d};
        @(negedge clk) req = '0;
        rd = rsp.rdata;
        er = rsp.valid ? rsp.err : 1'bx;
    endtask
    task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp, input string nm);
        bus(1'b0, a, 32'h0);
        chk(nm, rd, exp);
    endtask
    // skip two edges so a tick cannot snapshot positions from before the change
    task automatic wait_tick;
        int n;
        repeat (2) @(negedge clk);
        for (n = 0; n < TICK_N + 10 && tick !== 1'b1; n++) @(negedge clk);
        if (n >= TICK_N + 10)
        begin
            miscompares++;
            finish_test();
        end
        else
            repeat (3) @(negedge clk);
    endtask
    task automatic t_regs;
        rd_chk(16'h121c, 32'h0000_2710, "limit");
        rd_chk(16'h111e, 32'h0, "peak");
        rd_chk(16'h1e24, 32'h0, "dev");
        bus(1'b1, 16'h1e24, 32'h5);
        chk("dev write err", {31'h0, er}, 32'h1);
        bus(1'b0, 16'h0100, 32'h0);
        chk("unmapped err", {31'h0, er}, 32'h1);
    endtask
    task automatic t_limit;
        bus(1'b1, 16'h121c, 32'h0);
        rd_chk(16'h121c, 32'h1, "limit lo");
        bus(1'b1, 16'h121c, 32'h0300_0000);
        rd_chk(16'h121c, 32'h001e_8480, "limit hi");
        // 100 is about five times a minimum of 20 from max current over both gains
        bus(1'b1, 16'h121c, 32'h64);
        chk("limit write err", {31'h0, er}, 32'h0);
        rd_chk(16'h121c, 32'h64, "limit");
    endtask
    // raw 150 is over the limit, 50 left after feedforward is not
    task automatic t_track_ok;
        sp = 32'h3e8;
        fe = 32'h96;
        ff = 32'h64;
        wait_tick();
        chk("fault", {31'h0, fault.active}, 32'h0);
        rd_chk(16'h1e24, 32'h96, "dev");
        rd_chk(16'h111e, 32'h32, "peak");
    endtask
    // negative error of 150 after feedforward must trip
    task automatic t_trip;
        cls = 4'h5;
        fe = 32'hffff_ff38;
        ff = 32'hffff_ffce;
        wait_tick();
        chk("fault", {27'h0, fault.active, fault.err_class}, 32'h15);
        chk("stop", {31'h0, stop_motion}, 32'h1);
        rd_chk(16'h1e24, 32'hffff_ff38, "dev");
        rd_chk(16'h111e, 32'h96, "peak");
        bus(1'b1, 16'h111e, 32'h1234);
        rd_chk(16'h111e, 32'h0, "peak clr");
        fault_ack = 1'b1;
        @(negedge clk) fault_ack = 1'b0;
        repeat (2) @(negedge clk);
        chk("ack", {31'h0, fault.active}, 32'h0);
    endtask
    initial
    begin
        repeat (8) @(negedge clk);
        nrst = 1'b1;
        t_regs();
        t_limit();
        t_track_ok();
        t_trip();
        finish_test();
    end
endmodule
